/* File: hdl/ifr_feature_bank.sv */
/*
 Instruction-set feature identification bank with its coprocessor access
 port, plus the unlocked swap sequencer that the swap field describes.
 Assumes requests arrive synchronous to clock from the core pipeline and
 that the memory side holds ack high for one cycle per accepted request.
*/
`timescale 1ns/1ns
module ifr_feature_bank
   import ifr_pkg::*;
#(
   parameter logic [3:0] EXC_CODE = IFR_W1_EXC_DFLT,
   parameter logic [3:0] ENDIAN_CODE = IFR_W1_ENDIAN_DFLT
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,

   // Coprocessor access request
   input wire logic cp_valid,
   input ifr_cp_req_t cp_req,

   // Coprocessor access answer
   output logic cp_rsp_valid,
   output logic [31:0] cp_rsp_data,
   output logic cp_undef,

   // Swap enable bit from the system control register
   input wire logic swap_enable,

   // Swap request from the core
   input wire logic swp_valid,
   input wire logic swp_byte,
   input wire logic [31:0] swp_addr,
   input wire logic [31:0] swp_wdata,
   output logic swp_ready,

   // Swap answer
   output logic swp_done,
   output logic swp_undef,
   output logic [31:0] swp_rdata,

   // Memory port
   output ifr_mem_req_t mem_req,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata
);

   // Whole module state in one record
   typedef struct packed {
      ifr_state_t st;
      logic rsp_valid;
      logic rsp_undef;
      logic [31:0] rsp_data;
      logic swp_done;
      logic swp_undef;
      logic [31:0] swp_rdata;
      ifr_mem_req_t mem;
   } ifr_bank_state_t;

   ifr_bank_state_t s_r;
   ifr_bank_state_t s_nxt;

   logic hit0;
   logic hit1;
   logic hit;
   logic priv_ok;
   logic read_ok;
   logic [31:0] rom_word;

   // Reset image of the state record
   localparam ifr_bank_state_t IFR_BANK_RST = '{
      st: IFR_IDLE,
      rsp_valid: 1'b0,
      rsp_undef: 1'b0,
      rsp_data: IFR_ZERO,
      swp_done: 1'b0,
      swp_undef: 1'b0,
      swp_rdata: IFR_ZERO,
      mem: '0
   };

   // Constant feature words
   ifr_word_rom #(
      .EXC_CODE(EXC_CODE),
      .ENDIAN_CODE(ENDIAN_CODE)
   ) u_rom (
      .sel_word1(hit1),
      .word(rom_word)
   );

   // Address decode of the coprocessor move
   always_comb
   begin
      hit0 = ifr_match(cp_req, IFR_OPC2_W0);
      hit1 = ifr_match(cp_req, IFR_OPC2_W1);
      hit = hit0 || hit1;
   end

   // Security state is deliberately ignored: both states see one copy
   assign priv_ok = (cp_req.priv >= IFR_PRIV_MIN);
   assign read_ok = hit && priv_ok && !cp_req.write;

   // Next-state logic for access port and swap sequencer
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rsp_valid = 1'b0;
      s_nxt.rsp_undef = 1'b0;
      s_nxt.swp_done = 1'b0;
      s_nxt.swp_undef = 1'b0;

      // Access answer, one cycle after the request
      if (cp_valid && hit)
      begin
         s_nxt.rsp_valid = 1'b1;
         if (read_ok)
         begin
            s_nxt.rsp_data = rom_word;
         end
         else
         begin
            // Data left as it was so a refused read leaks nothing
            s_nxt.rsp_undef = 1'b1;
         end
      end

      // Swap sequencer
      case (s_r.st)
         IFR_IDLE:
         begin
            if (swp_valid)
            begin
               if (swap_enable)
               begin
                  s_nxt.mem.valid = 1'b1;
                  s_nxt.mem.write = 1'b0;
                  s_nxt.mem.lock = 1'b0;
                  s_nxt.mem.byte_only = swp_byte;
                  s_nxt.mem.addr = swp_addr;
                  s_nxt.mem.wdata = swp_wdata;
                  s_nxt.st = IFR_SWP_RD;
               end
               else
               begin
                  // Disabled swap is an undefined instruction
                  s_nxt.swp_undef = 1'b1;
               end
            end
         end
         IFR_SWP_RD:
         begin
            if (mem_ack)
            begin
               // Read done; write follows as a separate, unlocked access
               s_nxt.swp_rdata = mem_rdata;
               s_nxt.mem.write = 1'b1;
               s_nxt.mem.lock = 1'b0;
               s_nxt.st = IFR_SWP_WR;
            end
         end
         IFR_SWP_WR:
         begin
            if (mem_ack)
            begin
               s_nxt.mem = '0;
               s_nxt.swp_done = 1'b1;
               s_nxt.st = IFR_IDLE;
            end
         end
         default:
         begin
            s_nxt = IFR_BANK_RST;
         end
      endcase
   end

   // State register
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_r <= IFR_BANK_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // Outputs
   assign cp_rsp_valid = s_r.rsp_valid;
   assign cp_rsp_data = s_r.rsp_data;
   assign cp_undef = s_r.rsp_undef;
   assign swp_ready = (s_r.st == IFR_IDLE); // Handshake may be combinational
   assign swp_done = s_r.swp_done;
   assign swp_undef = s_r.swp_undef;
   assign swp_rdata = s_r.swp_rdata;
   assign mem_req = s_r.mem;

endmodule : ifr_feature_bank

/* File: hdl/ifr_pkg.sv */
/*
 Constants and carrier types for the instruction-set feature identification bank.
 Assumes a core-side coprocessor access port in the single core clock domain.
*/
// Function
// - Both words are read-only and return their value only at privilege level one or above; other accesses to them answer undefined.
// - One copy of each word serves secure and non-secure reads alike.
// - Word 0 bits 27:24 read 2: hardware divide in both instruction sets.
// - Word 0 bits 23:20 read 1: software breakpoint supported.
// - Word 0 bits 19:16 read 0: no generic coprocessor instructions.
// - Word 0 bits 15:12 read 1: compare-with-zero-and-branch supported.
// - Word 0 bits 11:8 read 1: bit-field clear, insert and extract supported.
// - Word 0 bits 7:4 read 1: count-leading-zeros supported.
// - Word 0 bits 3:0 read 0: swap only partially supported.
// - Enabled swap does a read then a write, bus never locked between.
// - Word 1 bits 31:28 read 1: bytecode-state branch and state bit.
// - Word 1 bits 27:24 read 3: interworking branches and exchange-like writes.
// - Word 1 bits 23:20 read 1: long immediate moves and add/subtract.
// - Word 1 bits 19:16 read 1: conditional block instruction supported.
// - Word 1 bits 15:12 read 2: extend instructions with dual and accumulate.
// - Word 1 bits 11:8 read 1: exception state save and return instructions.
// - Word 1 bits 7:4 hold the exception-return multiple-transfer code set by EXC_CODE.
package ifr_pkg;

   // Field geometry
   localparam int unsigned IFR_FW = 4;
   localparam int unsigned IFR_F7 = 28;
   localparam int unsigned IFR_F6 = 24;
   localparam int unsigned IFR_F5 = 20;
   localparam int unsigned IFR_F4 = 16;
   localparam int unsigned IFR_F3 = 12;
   localparam int unsigned IFR_F2 = 8;
   localparam int unsigned IFR_F1 = 4;
   localparam int unsigned IFR_F0 = 0;

   // Word 0 field values
   localparam logic [3:0] IFR_W0_RSVD = 4'h0;
   localparam logic [3:0] IFR_W0_DIVIDE = 4'h2;
   localparam logic [3:0] IFR_W0_BREAKPT = 4'h1;
   localparam logic [3:0] IFR_W0_COPROC = 4'h0;
   localparam logic [3:0] IFR_W0_CMP_BR = 4'h1;
   localparam logic [3:0] IFR_W0_BITFLD = 4'h1;
   localparam logic [3:0] IFR_W0_BITCNT = 4'h1;
   localparam logic [3:0] IFR_W0_SWAP = 4'h0;

   // Word 1 field values; the two lowest come in as parameters
   localparam logic [3:0] IFR_W1_BYTECODE = 4'h1;
   localparam logic [3:0] IFR_W1_INTERWORK = 4'h3;
   localparam logic [3:0] IFR_W1_IMMED = 4'h1;
   localparam logic [3:0] IFR_W1_COND_BLK = 4'h1;
   localparam logic [3:0] IFR_W1_EXTEND = 4'h2;
   localparam logic [3:0] IFR_W1_EXC_PROF = 4'h1;
   localparam logic [3:0] IFR_W1_EXC_DFLT = 4'h1;
   localparam logic [3:0] IFR_W1_ENDIAN_DFLT = 4'h1;

   // Coprocessor move encodings that select the two words
   localparam logic [2:0] IFR_OPC1 = 3'h0;
   localparam logic [3:0] IFR_CRN = 4'h0;
   localparam logic [3:0] IFR_CRM = 4'h2;
   localparam logic [2:0] IFR_OPC2_W0 = 3'h0;
   localparam logic [2:0] IFR_OPC2_W1 = 3'h1;

   // Least privilege level that may read
   localparam logic [1:0] IFR_PRIV_MIN = 2'h1;
   localparam logic [31:0] IFR_ZERO = 32'h0000_0000;

   // Coprocessor access request
   typedef struct packed {
      logic [2:0] opc1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] opc2;
      logic write;
      logic [1:0] priv;
      logic secure;
   } ifr_cp_req_t;

   // Memory-side request issued by the swap sequencer
   typedef struct packed {
      logic valid;
      logic write;
      logic byte_only;
      logic lock;
      logic [31:0] addr;
      logic [31:0] wdata;
   } ifr_mem_req_t;

   // Swap sequencer states
   typedef enum logic [1:0] {
      IFR_IDLE = 2'b00,
      IFR_SWP_RD = 2'b01,
      IFR_SWP_WR = 2'b10
   } ifr_state_t;

   // True when a request names the given word
   function automatic logic ifr_match(input ifr_cp_req_t r, input logic [2:0] opc2);
      ifr_match = (r.opc1 == IFR_OPC1) && (r.crn == IFR_CRN) &&
                  (r.crm == IFR_CRM) && (r.opc2 == opc2);
   endfunction : ifr_match

endpackage : ifr_pkg

/* File: hdl/ifr_word_rom.sv */
/*
 Constant feature words for the identification bank.
 Assumes the caller picks one word per cycle by select.
*/
`timescale 1ns/1ns
module ifr_word_rom
   import ifr_pkg::*;
#(
   parameter logic [3:0] EXC_CODE = IFR_W1_EXC_DFLT,
   parameter logic [3:0] ENDIAN_CODE = IFR_W1_ENDIAN_DFLT
)
(
   // Selection
   input wire logic sel_word1,
   // Result
   output logic [31:0] word
);

   logic [31:0] word0;
   logic [31:0] word1;

   // Word 0, top field reserved as zero
   always_comb
   begin
      word0 = IFR_ZERO;
      word0[IFR_F7 +: IFR_FW] = IFR_W0_RSVD;
      word0[IFR_F6 +: IFR_FW] = IFR_W0_DIVIDE;
      word0[IFR_F5 +: IFR_FW] = IFR_W0_BREAKPT;
      word0[IFR_F4 +: IFR_FW] = IFR_W0_COPROC;
      word0[IFR_F3 +: IFR_FW] = IFR_W0_CMP_BR;
      word0[IFR_F2 +: IFR_FW] = IFR_W0_BITFLD;
      word0[IFR_F1 +: IFR_FW] = IFR_W0_BITCNT;
      word0[IFR_F0 +: IFR_FW] = IFR_W0_SWAP;
   end

   // Word 1
   always_comb
   begin
      word1 = IFR_ZERO;
      word1[IFR_F7 +: IFR_FW] = IFR_W1_BYTECODE;
      word1[IFR_F6 +: IFR_FW] = IFR_W1_INTERWORK;
      word1[IFR_F5 +: IFR_FW] = IFR_W1_IMMED;
      word1[IFR_F4 +: IFR_FW] = IFR_W1_COND_BLK;
      word1[IFR_F3 +: IFR_FW] = IFR_W1_EXTEND;
      word1[IFR_F2 +: IFR_FW] = IFR_W1_EXC_PROF;
      word1[IFR_F1 +: IFR_FW] = EXC_CODE;
      word1[IFR_F0 +: IFR_FW] = ENDIAN_CODE;
   end

   // Output select
   assign word = sel_word1 ? word1 : word0;

endmodule : ifr_word_rom

/* File: testbench/ifr_feature_bank_monitor.sv */
/*
 Assertion checker for the feature identification bank.
 Assumes it is bound to the bank and sees only its ports.
*/
`timescale 1ns/1ns
module ifr_feature_bank_monitor
   import ifr_pkg::*;
#(
   parameter logic [3:0] EXC_CODE = IFR_W1_EXC_DFLT,
   parameter logic [3:0] ENDIAN_CODE = IFR_W1_ENDIAN_DFLT
)
(
   // Clock, reset and access port
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cp_valid,
   input ifr_cp_req_t cp_req,
   input logic cp_rsp_valid,
   input logic [31:0] cp_rsp_data,
   input logic cp_undef,
   // Swap and memory side
   input wire logic swap_enable,
   input wire logic swp_valid,
   input logic swp_ready,
   input logic swp_done,
   input logic swp_undef,
   input ifr_mem_req_t mem_req,
   input wire logic mem_ack
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // Decode kept apart from the bank's own helper so a shared slip shows
   logic hit;
   logic bad;
   assign hit = cp_valid && cp_req.opc1 == 3'h0 && cp_req.crn == 4'h0 &&
                cp_req.crm == 4'h2 && cp_req.opc2 < 3'h2;
   assign bad = cp_req.write || cp_req.priv < 2'h1;

   a_good_read:
      assert property (hit && !bad |=> cp_rsp_valid && !cp_undef) else $error("read lost");
   a_word0_bits:
      assert property (hit && !bad && cp_req.opc2 == 3'h0 |=> cp_rsp_data == 32'h02101110)
      else $error("word0 wrong");
   a_word1_bits:
      assert property (hit && !bad && cp_req.opc2 == 3'h1 |=>
         cp_rsp_data == {24'h131121, EXC_CODE, ENDIAN_CODE}) else $error("word1 wrong");
   a_refuse_undef:
      assert property (hit && bad |=> cp_rsp_valid && cp_undef) else $error("no undef");
   a_refuse_keep:
      assert property (hit && bad |=> $stable(cp_rsp_data)) else $error("data changed");
   a_miss_silent:
      assert property (!hit |=> !cp_rsp_valid) else $error("stray answer");
   a_swap_read:
      assert property (swp_valid && swp_ready && swap_enable |=> mem_req.valid && !mem_req.write)
      else $error("swap not read first");
   a_swap_off:
      assert property (swp_valid && swp_ready && !swap_enable |=> swp_undef && !mem_req.valid)
      else $error("disabled swap ran");
   a_bus_unlocked:
      assert property (mem_req.valid |-> !mem_req.lock) else $error("bus locked");
   a_read_then_write:
      assert property (mem_req.valid && !mem_req.write && mem_ack |=>
         mem_req.valid && mem_req.write) else $error("write missing");
   a_done_after:
      assert property (mem_req.valid && mem_req.write && mem_ack |=> swp_done)
      else $error("done missing");
endmodule : ifr_feature_bank_monitor

bind ifr_feature_bank ifr_feature_bank_monitor #(.EXC_CODE(EXC_CODE),
   .ENDIAN_CODE(ENDIAN_CODE)) i_mon (.clock(clock), .rst_n(rst_n), .cp_valid(cp_valid),
   .cp_req(cp_req), .cp_rsp_valid(cp_rsp_valid), .cp_rsp_data(cp_rsp_data),
   .cp_undef(cp_undef), .swap_enable(swap_enable), .swp_valid(swp_valid),
   .swp_ready(swp_ready), .swp_done(swp_done), .swp_undef(swp_undef),
   .mem_req(mem_req), .mem_ack(mem_ack));

/* File: testbench/test_ifr_feature_bank.sv */
/*
 Self-checking bench for the feature identification bank.
 Assumes the bench plays both the core and the memory side.
*/
`timescale 1ns/1ns
module test_ifr_feature_bank;
   import ifr_pkg::*;
   // Odd low codes prove the parameters reach the word
   localparam logic [31:0] W0 = 32'h02101110;
   localparam logic [31:0] W1 = 32'h1311215a;
   logic clock = 0, rst_n = 0, cp_valid = 0, swap_enable = 0;
   logic swp_valid = 0, swp_byte = 0, mem_ack = 0;
   logic [31:0] swp_addr = 0, swp_wdata = 0, mem_rdata = 0, last = 0;
   ifr_cp_req_t cp_req = '0;
   ifr_mem_req_t mem_req;
   logic cp_rsp_valid, cp_undef, swp_ready, swp_done, swp_undef;
   logic [31:0] cp_rsp_data, swp_rdata;
   logic [34:0] e;
   logic [34:0] cq[$];
   logic [34:0] sq[$];
   int errors = 0, comparisons = 0, seed = 32'hf500;

   ifr_feature_bank #(.EXC_CODE(4'h5), .ENDIAN_CODE(4'ha)) i_dut (.clock(clock),
      .rst_n(rst_n), .cp_valid(cp_valid), .cp_req(cp_req), .cp_rsp_valid(cp_rsp_valid),
      .cp_rsp_data(cp_rsp_data), .cp_undef(cp_undef), .swap_enable(swap_enable),
      .swp_valid(swp_valid), .swp_byte(swp_byte), .swp_addr(swp_addr),
      .swp_wdata(swp_wdata), .swp_ready(swp_ready), .swp_done(swp_done),
      .swp_undef(swp_undef), .swp_rdata(swp_rdata), .mem_req(mem_req),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   // Clock
   always #2 clock = ~clock;

   task automatic check(input logic [34:0] seen, input logic [34:0] exp);
   begin
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask : check

   // One access per call; calls in a row give back-to-back requests
   task automatic acc(input logic [2:0] o2, input logic [3:0] crm, input logic wr,
                      input logic [1:0] pv);
   begin
      @(posedge clock);
      #1;
      cp_valid = 1;
      cp_req = '{3'h0, 4'h0, crm, o2, wr, pv, 1'($random(seed))};
      if (crm == 4'h2 && o2 < 3'h2)
      begin
         if (wr || pv == 2'h0)
            cq.push_back({3'b001, last});
         else
         begin
            last = o2[0] ? W1 : W0;
            cq.push_back({3'b000, last});
         end
      end
   end
   endtask : acc

   // Memory side: stalls a random while, then acknowledges once
   task automatic mem(input logic [34:0] exp, input logic [31:0] d, input logic [31:0] rv);
      int n;
   begin
      n = 0;
      while (mem_req.valid !== 1'b1 && n < 9)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      repeat (2'($random(seed)))
      begin
         @(posedge clock);
         #1;
      end
      check({mem_req.valid, mem_req.byte_only, mem_req.write, mem_req.addr}, exp);
      check({33'b0, swp_ready, mem_req.lock}, 35'h0);
      if (exp[32])
         check({3'b0, mem_req.wdata}, {3'b0, d});
      mem_ack = 1;
      mem_rdata = rv;
      @(posedge clock);
      #1;
      mem_ack = 0;
      mem_rdata = ~rv;
   end
   endtask : mem

   task automatic swp(input logic en, input logic [31:0] rv);
      logic [31:0] a;
      logic [31:0] d;
      logic b;
   begin
      a = $random(seed);
      d = $random(seed);
      b = 1'($random(seed));
      @(posedge clock);
      #1;
      swap_enable = en;
      swp_valid = 1;
      swp_byte = b;
      swp_addr = a;
      swp_wdata = d;
      sq.push_back(en ? {3'b000, rv} : {3'b001, 32'h0});
      @(posedge clock);
      #1;
      swp_valid = 0;
      swp_addr = ~a;
      swp_wdata = ~d;
      if (en)
      begin
         mem({1'b1, b, 1'b0, a}, d, rv);
         mem({1'b1, b, 1'b1, a}, d, ~rv);
      end
   end
   endtask : swp

   task automatic conclude;
   begin
      check(35'(cq.size() + sq.size()), 35'h0);
      if (errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask : conclude

   // Results are compared at the falling edge, where they have settled
   always @(negedge clock)
   begin
      if (cp_rsp_valid === 1'b1)
      begin
         e = cq.size() ? cq.pop_front() : '1;
         check({2'b0, cp_undef, cp_rsp_data}, e);
      end
      if (swp_done === 1'b1 || swp_undef === 1'b1)
      begin
         e = sq.size() ? sq.pop_front() : '1;
         check({2'b0, swp_undef, swp_done ? swp_rdata : 32'h0}, e);
      end
   end

   // Watchdog
   initial
   begin
      #20000;
      errors++;
      conclude();
   end

   // Main sequence
   initial
   begin
      repeat (4) @(posedge clock);
      #1;
      rst_n = 1;
      for (int i = 0; i < 48; i++)
         acc(3'(i % 3), (i % 7 == 6) ? 4'h3 : 4'h2, i % 5 == 4, 2'($random(seed)));
      @(posedge clock);
      #1;
      cp_valid = 0;
      for (int i = 0; i < 6; i++)
         swp(i % 3 != 0, $random(seed));
      repeat (4) @(posedge clock);
      conclude();
   end
endmodule : test_ifr_feature_bank
